// ---- lsr_conv.sv ----
// integration timer of the two converters and their result capture
// assumes adc counts arrive on the core clock and hold while integration runs
`timescale 1ns/1ns
`default_nettype none

module lsr_conv import lsr_pkg::*; #(
   parameter int INTEG_LONG = INTEG_LONG_CYC
) (
   input wire logic clock, // core clock
   input wire logic rstn, // async reset, active low
   input wire logic power_on, // 0 = power down
   input wire logic [1:0] integ_sel, // integration time select
   input wire logic [DATA_W-1:0] adc_ch0, // broadband converter count
   input wire logic [DATA_W-1:0] adc_ch1, // infrared converter count
   output logic afe_integrate, // both integrators run while high
   output logic conv_done, // one-cycle pulse, results valid
   output logic [DATA_W-1:0] conv_ch0, // captured channel 0
   output logic [DATA_W-1:0] conv_ch1 // captured channel 1
);

   if (INTEG_LONG < 2 * INTEG_SHORT_DIV || INTEG_LONG >= (1 << CNT_W)) begin : g_chk
      $error("integration count out of range");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic busy;
      logic done;
      logic [DATA_W-1:0] ch0;
      logic [DATA_W-1:0] ch1;
   } lsr_conv_type;

   lsr_conv_type r, n;

   // cycles of one integration for the selected time
   function automatic logic [CNT_W-1:0] integ_limit(input logic [1:0] sel);
      logic [CNT_W-1:0] full;
      full = CNT_W'(INTEG_LONG);
      unique case (sel)
         INTEG_SHORT: integ_limit = CNT_W'(INTEG_LONG / INTEG_SHORT_DIV);
         INTEG_MID: integ_limit = CNT_W'(INTEG_LONG / INTEG_MID_DIV);
         default: integ_limit = full;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // integration sequencer
   // ----------------------------------------------------------------
   // one shared counter times both channels, so they see the same interval
   always_comb begin
      n = r;
      n.done = 1'b0;
      if (!power_on) begin
         n.busy = 1'b0;
         n.cnt = '0;
      end else begin
         n.busy = 1'b1;
         if (r.cnt >= integ_limit(integ_sel) - CNT_W'(1)) begin
            n.done = 1'b1;
            n.ch0 = adc_ch0;
            n.ch1 = adc_ch1;
            n.cnt = '0;
         end else begin
            n.cnt = r.cnt + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign afe_integrate = r.busy;
   assign conv_done = r.done;
   assign conv_ch0 = r.ch0;
   assign conv_ch1 = r.ch1;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   conv_restart_a: assert property (
      (r.done && power_on) |=> r.cnt == CNT_W'(1))
      else $error("integration did not restart after transfer");
   power_down_a: assert property (
      !power_on |=> !r.busy && !r.done)
      else $error("conversion ran in power down");
   both_integ_a: assert property (
      r.done |-> $past(r.busy))
      else $error("result without integration");

endmodule

`default_nettype wire

// ---- lsr_host.sv ----
// host-side master of the two-wire link, clocked by the core clock
// assumes pull-ups on both wires; the device only ever pulls sda low
`timescale 1ns/1ns
`default_nettype none

module lsr_host import lsr_pkg::*; #(
   parameter int HALF = 8
) (
   input wire logic clock, // core clock
   input wire logic sda_oe, // device pulls sda low
   output var logic scl, // link clock wire
   output logic sda // link data wire level
);
   logic m_pull = 1'b0;
   initial scl = 1'b1;
   // pull-up: a released wire reads high, never the last value
   assign sda = ~(m_pull | sda_oe);

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // scl stands high between frames; each scl phase spans HALF core cycles
   task automatic frame_start();
      m_pull <= 1'b0;
      tick(HALF);
      m_pull <= 1'b1;
      tick(HALF);
      scl <= 1'b0;
      tick(HALF/2);
   endtask

   // data changes only while scl is low, sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      m_pull <= ~b;
      tick(HALF/2);
      scl <= 1'b1;
      tick(HALF/2);
      // sample between edges, away from the edge that moves the device's drive
      @(negedge clock);
      r = sda;
      tick(HALF/2);
      scl <= 1'b0;
      tick(HALF/2);
   endtask

   // ab is the level put on the ninth bit: 1 releases it for the device
   task automatic xfer(input logic [7:0] wb, input logic ab, output logic [7:0] rb,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(wb[i], rb[i]);
      bit_io(ab, r);
      ack = ~r;
   endtask

   task automatic frame_stop();
      m_pull <= 1'b1;
      tick(HALF/2);
      scl <= 1'b1;
      tick(HALF);
      m_pull <= 1'b0;
      tick(HALF);
   endtask
endmodule

`default_nettype wire

// ---- lsr_pkg.sv ----
// shared constants and the link state type of the two-channel light readout
// assumes a single 25 MHz core clock; the link pins are sampled by that clock
package lsr_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int T_INTEG_LONG_US = 402_000;
   localparam int INTEG_LONG_CYC = T_INTEG_LONG_US * (CLK_HZ / 1_000_000);
   localparam int INTEG_MID_DIV = 4;
   localparam int INTEG_SHORT_DIV = 16;
   localparam int T_SMB_MAX_KHZ = 100;
   localparam int T_I2C_MAX_KHZ = 400;
   // fewest core cycles in half a link clock period at the fastest rate
   localparam int SCL_HALF_CYC = CLK_HZ / (2 * T_I2C_MAX_KHZ * 1000);
   localparam int SCL_HALF_MIN_CYC = 8;

   // ----------------------------------------------------------------
   // widths and codes
   // ----------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int PERSIST_W = 4;
   localparam int CNT_W = 24;
   localparam logic [1:0] SEL_GND = 2'h0;
   localparam logic [1:0] SEL_FLOAT = 2'h1;
   localparam logic [1:0] SEL_VDD = 2'h2;
   localparam logic [1:0] INTEG_SHORT = 2'h0;
   localparam logic [1:0] INTEG_MID = 2'h1;
   // slave addresses per select state, values arbitrary
   localparam logic [6:0] ADDR_GND = 7'h21;
   localparam logic [6:0] ADDR_FLOAT = 7'h31;
   localparam logic [6:0] ADDR_VDD = 7'h41;
   // smbus alert response address
   localparam logic [6:0] ADDR_ALERT = 7'h0c;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // ----------------------------------------------------------------
   // serial link states
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      LS_IDLE = 7'h01,
      LS_ADDR = 7'h02,
      LS_ACKA = 7'h04,
      LS_TX = 7'h08,
      LS_RACK = 7'h10,
      LS_RX = 7'h20,
      LS_ACKW = 7'h40
   } lsr_link_type;

endpackage

// ---- lsr_readout.sv ----
// two-channel light readout: serial slave, double-buffered results, thresholds
// assumes scl, sda and the select pad are asynchronous and sampled here
`timescale 1ns/1ns
`default_nettype none

// Contract
// - both channels integrate together over one identical interval.
// - on completion, channel 0 and channel 1 results land in their data registers.
// - reads use a shadow copy, never mixing old and new results.
// - next integration starts by itself right after the transfer.
// - every channel result given to the host is 16 bits.
// - upper and lower thresholds; a channel 0 value beyond either raises the interrupt.
// - persistence count delays the interrupt until out of range long enough.
// - level interrupt stays asserted until the host clears it.
// - in smbus mode the interrupt is an alert, released by alert response.
// - interrupt pin is open drain, only ever pulled low.
// - slave address chosen by the three-state select pad.
// - link runs up to 100 kHz smbus or 400 kHz fast mode.
// - host sets analog gain and integration time; here via the gain_hi and integ_sel pins, not the link.
// - power down stops conversions.
module lsr_readout import lsr_pkg::*; #(
   parameter int INTEG_LONG = INTEG_LONG_CYC
) (
   input wire logic clock, // core clock, 25 MHz
   input wire logic rstn, // async reset, active low
   input wire logic scl_i, // link clock pin
   input wire logic sda_i, // link data pin level
   output logic sda_o, // link data drive value, always low
   output logic sda_oe, // pulls sda low while high
   output logic int_oe, // pulls interrupt pin low while high
   input wire logic [1:0] addr_sel, // select pad state code
   input wire logic smb_mode, // 1 = smbus alert style
   input wire logic power_on, // 0 = power down
   input wire logic gain_hi, // high analog gain
   input wire logic [1:0] integ_sel, // integration time select
   input wire logic int_en, // threshold interrupt enable
   input wire logic [DATA_W-1:0] thr_lo, // lower threshold
   input wire logic [DATA_W-1:0] thr_hi, // upper threshold
   input wire logic [PERSIST_W-1:0] persist, // conversions out of range needed
   input wire logic [DATA_W-1:0] adc_ch0, // broadband converter count
   input wire logic [DATA_W-1:0] adc_ch1, // infrared converter count
   output logic afe_integrate, // integrators run
   output logic afe_gain_hi, // gain to front end
   output logic [DATA_W-1:0] ch0_data, // channel 0 data register
   output logic [DATA_W-1:0] ch1_data, // channel 1 data register
   output logic int_pend, // interrupt pending
   output logic [6:0] own_addr // latched slave address
);

   if (SCL_HALF_CYC < SCL_HALF_MIN_CYC) begin : g_chk
      $error("core clock too slow to sample the link");
   end

   typedef struct packed {
      logic scl_m, scl_s, scl_d;
      logic sda_m, sda_s, sda_d;
      logic [1:0] sel_m, sel_s;
      logic [1:0] strap_cnt;
      logic strap_ok;
      logic [6:0] addr;
      lsr_link_type st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic ara;
      logic [1:0] ptr;
      logic oe;
      logic [DATA_W-1:0] data0, data1;
      logic [DATA_W-1:0] shd0, shd1;
      logic [PERSIST_W-1:0] pcnt;
      logic pend;
   } lsr_top_type;

   lsr_top_type r, n;
   logic conv_done;
   logic [DATA_W-1:0] conv_ch0, conv_ch1;
   logic rise, fall, start, stop, wr_clr, ara_clr, out_rng, fire;
   logic [7:0] tx_byte;
   logic [PERSIST_W-1:0] pnext;

   // ----------------------------------------------------------------
   // converter sequencing
   // ----------------------------------------------------------------
   lsr_conv #(.INTEG_LONG(INTEG_LONG)) u_conv (
      .clock(clock),
      .rstn(rstn),
      .power_on(power_on),
      .integ_sel(integ_sel),
      .adc_ch0(adc_ch0),
      .adc_ch1(adc_ch1),
      .afe_integrate(afe_integrate),
      .conv_done(conv_done),
      .conv_ch0(conv_ch0),
      .conv_ch1(conv_ch1)
   );

   // address for each pad state; an undefined code counts as floating
   function automatic logic [6:0] sel_addr(input logic [1:0] sel);
      unique case (sel)
         SEL_GND: sel_addr = ADDR_GND;
         SEL_VDD: sel_addr = ADDR_VDD;
         default: sel_addr = ADDR_FLOAT;
      endcase
   endfunction

   // read byte order: ch0 low, ch0 high, ch1 low, ch1 high
   function automatic logic [7:0] pick(input logic [DATA_W-1:0] a,
                                       input logic [DATA_W-1:0] b,
                                       input logic [1:0] p);
      unique case (p)
         2'h0: pick = a[7:0];
         2'h1: pick = a[15:8];
         2'h2: pick = b[7:0];
         default: pick = b[15:8];
      endcase
   endfunction

   // ----------------------------------------------------------------
   // link edge and condition detection
   // ----------------------------------------------------------------
   // only second-stage and delayed copies are looked at; at 400 kHz a
   // half period still spans over thirty core cycles
   always_comb begin
      rise = r.scl_s & ~r.scl_d;
      fall = ~r.scl_s & r.scl_d;
      start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
      stop = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
      tx_byte = pick(r.shd0, r.shd1, r.ptr);
   end

   // threshold and persistence decision for the arriving result
   always_comb begin
      out_rng = (conv_ch0 > thr_hi) || (conv_ch0 < thr_lo);
      pnext = (r.pcnt == '1) ? r.pcnt : r.pcnt + PERSIST_W'(1);
      fire = (persist == '0) || (out_rng && pnext >= persist);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      wr_clr = 1'b0;
      ara_clr = 1'b0;
      n.scl_m = scl_i;
      n.scl_s = r.scl_m;
      n.scl_d = r.scl_s;
      n.sda_m = sda_i;
      n.sda_s = r.sda_m;
      n.sda_d = r.sda_s;
      n.sel_m = addr_sel;
      n.sel_s = r.sel_m;
      // strap caught a few cycles after reset release, once only
      if (!r.strap_ok) begin
         n.strap_cnt = r.strap_cnt + 2'h1;
         if (r.strap_cnt == STRAP_WAIT) begin
            n.strap_ok = 1'b1;
            n.addr = sel_addr(r.sel_s);
         end
      end
      if (!r.strap_ok) begin
         n.st = LS_IDLE;
      end else if (start) begin
         n.st = LS_ADDR;
         n.bitcnt = '0;
         n.oe = 1'b0;
         n.ara = 1'b0;
      end else if (stop) begin
         n.st = LS_IDLE;
         n.oe = 1'b0;
      end else begin
         unique case (r.st)
            LS_IDLE: begin
            end
            LS_ADDR: begin
               if (rise) begin
                  n.shreg = {r.shreg[6:0], r.sda_s};
                  n.bitcnt = r.bitcnt + 4'h1;
               end else if (fall && r.bitcnt == BITS_BYTE) begin
                  n.bitcnt = '0;
                  n.rw = r.shreg[0];
                  n.ptr = '0;
                  if (r.shreg[7:1] == r.addr) begin
                     n.st = LS_ACKA;
                     n.oe = 1'b1;
                     n.shd0 = r.data0;
                     n.shd1 = r.data1;
                  end else if (r.shreg[7:1] == ADDR_ALERT && r.shreg[0] && smb_mode
                               && r.pend) begin
                     n.st = LS_ACKA;
                     n.oe = 1'b1;
                     n.ara = 1'b1;
                  end else begin
                     n.st = LS_IDLE;
                  end
               end
            end
            LS_ACKA: begin
               if (fall) begin
                  if (r.rw) begin
                     n.st = LS_TX;
                     n.shreg = r.ara ? {r.addr, 1'b0} : tx_byte;
                     n.oe = r.ara ? ~r.addr[6] : ~tx_byte[7];
                     n.ptr = r.ara ? r.ptr : r.ptr + 2'h1;
                  end else begin
                     n.st = LS_RX;
                     n.oe = 1'b0;
                  end
               end
            end
            LS_TX: begin
               if (rise) begin
                  n.bitcnt = r.bitcnt + 4'h1;
               end else if (fall) begin
                  if (r.bitcnt == BITS_BYTE) begin
                     n.st = LS_RACK;
                     n.oe = 1'b0;
                     n.bitcnt = '0;
                  end else begin
                     n.shreg = {r.shreg[6:0], 1'b0};
                     n.oe = ~r.shreg[6];
                  end
               end
            end
            LS_RACK: begin
               if (rise) begin
                  ara_clr = r.ara;
                  n.ara = 1'b0;
                  if (r.sda_s) begin
                     n.st = LS_IDLE;
                  end
               end else if (fall) begin
                  n.st = LS_TX;
                  n.shreg = tx_byte;
                  n.oe = ~tx_byte[7];
                  n.ptr = r.ptr + 2'h1;
               end
            end
            LS_RX: begin
               if (rise) begin
                  n.shreg = {r.shreg[6:0], r.sda_s};
                  n.bitcnt = r.bitcnt + 4'h1;
               end else if (fall && r.bitcnt == BITS_BYTE) begin
                  n.st = LS_ACKW;
                  n.oe = 1'b1;
                  n.bitcnt = '0;
                  wr_clr = 1'b1;
               end
            end
            LS_ACKW: begin
               if (fall) begin
                  n.st = LS_RX;
                  n.oe = 1'b0;
               end
            end
            default: begin
               n.st = LS_IDLE;
               n.oe = 1'b0;
            end
         endcase
      end
      // result transfer and the threshold check share the same instant
      if (conv_done) begin
         n.data0 = conv_ch0;
         n.data1 = conv_ch1;
         n.pcnt = out_rng ? pnext : '0;
      end
      // a new event wins over a clear in the same cycle
      n.pend = (conv_done && int_en && fire) || (r.pend && !wr_clr && !ara_clr);
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign sda_o = 1'b0;
   assign sda_oe = r.oe;
   assign int_oe = r.pend;
   assign afe_gain_hi = gain_hi;
   assign ch0_data = r.data0;
   assign ch1_data = r.data1;
   assign int_pend = r.pend;
   assign own_addr = r.addr;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   data_xfer_a: assert property (
      conv_done |=> r.data0 == $past(conv_ch0) && r.data1 == $past(conv_ch1))
      else $error("results not transferred");
   shadow_hold_a: assert property (
      (r.st == LS_TX || r.st == LS_RACK) |=> $stable(r.shd0) && $stable(r.shd1))
      else $error("shadow changed during read");
   int_hold_a: assert property (
      (r.pend && !wr_clr && !ara_clr) |=> r.pend)
      else $error("interrupt dropped without clear");
   int_cause_a: assert property (
      $rose(r.pend) |-> $past(conv_done) && $past(int_en))
      else $error("interrupt raised outside a conversion");
   thr_fire_a: assert property (
      (conv_done && int_en && persist == 4'h1 && conv_ch0 > thr_hi) |=> r.pend && int_oe)
      else $error("upper threshold missed");
   persist_wait_a: assert property (
      (conv_done && !r.pend && persist > 4'h1 && r.pcnt == 4'h0) |=> !r.pend)
      else $error("interrupt before persistence met");
   alert_mode_a: assert property (
      $rose(r.ara) |-> $past(smb_mode) && $past(r.pend))
      else $error("alert response outside smbus mode");
   addr_ack_a: assert property (
      (r.st == LS_ADDR && fall && r.bitcnt == 4'h8 && r.shreg[7:1] == r.addr && !start
       && !stop) |=> r.st == LS_ACKA && sda_oe)
      else $error("own address not acknowledged");

   conv_seen_c: cover property ((conv_done && out_rng) ##1 r.pend);
   int_raise_c: cover property ($rose(r.pend));
   read_ack_c: cover property ((r.st == LS_ACKA && r.rw && !r.ara && fall) ##1 r.st == LS_TX);
   alert_c: cover property ($fell(r.pend) && $past(ara_clr));

endmodule

`default_nettype wire

// ---- tb.sv ----
// self-checking bench of the two-channel light readout
// assumes lsr_host as link master and a short integration time
`timescale 1ns/1ns
`default_nettype none

module tb import lsr_pkg::*;;
   localparam int LONG = 64;
   logic clock, rstn, scl, sda, sda_o, sda_oe, int_oe, smb_mode, power_on, gain_hi;
   logic int_en, afe_integrate, afe_gain_hi, int_pend;
   logic [1:0] addr_sel, integ_sel;
   logic [3:0] persist;
   logic [15:0] thr_lo, thr_hi, adc_ch0, adc_ch1, ch0_data, ch1_data, tok;
   logic [6:0] own_addr, exp_addr;
   int fail_count = 0;
   int n_compared = 0;

   // ----------------------------------------------------------------
   // clock, design and link master
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   lsr_readout #(.INTEG_LONG(LONG)) u_lsr_readout (.clock(clock), .rstn(rstn), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .int_oe(int_oe), .addr_sel(addr_sel),
      .smb_mode(smb_mode), .power_on(power_on), .gain_hi(gain_hi), .integ_sel(integ_sel),
      .int_en(int_en), .thr_lo(thr_lo), .thr_hi(thr_hi), .persist(persist),
      .adc_ch0(adc_ch0), .adc_ch1(adc_ch1), .afe_integrate(afe_integrate),
      .afe_gain_hi(afe_gain_hi), .ch0_data(ch0_data), .ch1_data(ch1_data),
      .int_pend(int_pend), .own_addr(own_addr));
   lsr_host #(.HALF(4)) u_host (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] sel);
      rstn <= 1'b0;
      addr_sel <= sel;
      tick(10);
      chk(int_oe, 0, "int pin driven in reset");
      rstn <= 1'b1;
      tick(10);
   endtask

   // each call lands exactly one conversion, marked by a fresh channel 1 token
   task automatic wait_conv(input logic [15:0] c0);
      int n;
      tok = tok + 16'h1;
      adc_ch0 <= c0;
      adc_ch1 <= tok;
      n = 0;
      while (ch1_data !== tok && n < 4*LONG) begin
         tick(1);
         n++;
      end
      chk(ch1_data, tok, "channel 1 register");
      chk(ch0_data, c0, "channel 0 register");
   endtask

   // a single written byte clears a pending interrupt
   task automatic hwrite();
      logic [7:0] rb;
      logic a;
      u_host.frame_start();
      u_host.xfer({exp_addr, 1'b0}, 1'b1, rb, a);
      u_host.xfer(8'h00, 1'b1, rb, a);
      u_host.frame_stop();
      chk(a, 1, "write byte ack");
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_strap();
      logic [6:0] tbl [3];
      tbl = '{ADDR_GND, ADDR_FLOAT, ADDR_VDD};
      for (int s = 0; s < 3; s++) begin
         do_reset(s[1:0]);
         chk(own_addr, tbl[s], "strap address");
      end
      exp_addr = ADDR_VDD;
      $display("test strap done");
   endtask

   task automatic t_conv();
      time t0;
      logic [1:0] sel [3];
      int lim [3];
      sel = '{2'h0, 2'h1, 2'h2};
      lim = '{LONG / INTEG_SHORT_DIV, LONG / INTEG_MID_DIV, LONG};
      // back-to-back conversions are one integration time apart in every mode
      for (int k = 0; k < 3; k++) begin
         integ_sel <= sel[k];
         wait_conv(16'h1234);
         t0 = $time;
         wait_conv(16'hffff);
         chk(16'(($time - t0) / 40), 16'(lim[k]), "conversion period");
      end
      chk(afe_integrate, 1, "restart");
      for (int g = 0; g < 2; g++) begin
         gain_hi <= g[0];
         tick(1);
         chk(afe_gain_hi, g, "gain");
      end
      $display("test conversion done");
   endtask

   task automatic t_read();
      logic [7:0] rb;
      logic [7:0] b [4];
      logic a;
      wait_conv(16'ha55a);
      u_host.frame_start();
      u_host.xfer({exp_addr, 1'b1}, 1'b1, rb, a);
      chk(a, 1, "own address ack");
      adc_ch0 <= 16'hb00b;
      adc_ch1 <= 16'h0bb0;
      for (int i = 0; i < 4; i++) u_host.xfer(8'hff, i == 3, b[i], a);
      u_host.frame_stop();
      chk({b[1], b[0]}, 16'ha55a, "channel 0 snapshot");
      chk({b[3], b[2]}, tok, "channel 1 snapshot");
      chk(sda_o, 0, "sda drive level");
      u_host.frame_start();
      u_host.xfer({7'h55, 1'b1}, 1'b1, rb, a);
      u_host.frame_stop();
      chk(a, 0, "foreign address");
      $display("test read done");
   endtask

   task automatic t_thresh();
      int_en <= 1'b1;
      thr_lo <= 16'h0064;
      thr_hi <= 16'h00c8;
      persist <= 4'h1;
      wait_conv(16'h0096);
      hwrite();
      wait_conv(16'h0096);
      chk(int_pend, 0, "in range");
      wait_conv(16'h012c);
      chk(int_pend, 1, "above upper");
      chk(int_oe, 1, "pin pulled");
      wait_conv(16'h0096);
      chk(int_pend, 1, "level held");
      hwrite();
      chk(int_pend, 0, "cleared by write");
      wait_conv(16'h0032);
      chk(int_pend, 1, "below lower");
      wait_conv(16'h0096);
      hwrite();
      persist <= 4'h3;
      wait_conv(16'h012c);
      wait_conv(16'h0096);
      wait_conv(16'h012c);
      wait_conv(16'h012c);
      chk(int_pend, 0, "persistence not met");
      wait_conv(16'h012c);
      chk(int_pend, 1, "persistence met");
      $display("test threshold done");
   endtask

   task automatic t_alert();
      logic [7:0] rb;
      logic a;
      wait_conv(16'h0096);
      for (int m = 0; m < 2; m++) begin
         smb_mode <= m[0];
         u_host.frame_start();
         u_host.xfer({ADDR_ALERT, 1'b1}, 1'b1, rb, a);
         if (a === 1'b1) u_host.xfer(8'hff, 1'b1, rb, a);
         u_host.frame_stop();
         chk(int_pend, !m, "alert clear");
      end
      chk(rb, {exp_addr, 1'b0}, "alert reply");
      $display("test alert done");
   endtask

   task automatic t_power();
      power_on <= 1'b0;
      tick(4);
      chk(afe_integrate, 0, "power down");
      adc_ch1 <= ~tok;
      tick(4*LONG);
      chk(ch1_data, tok, "no conversion");
      power_on <= 1'b1;
      wait_conv(16'h0777);
      $display("test power done");
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      addr_sel = 2'h0;
      smb_mode = 1'b0;
      power_on = 1'b1;
      gain_hi = 1'b0;
      integ_sel = 2'h2;
      int_en = 1'b0;
      thr_lo = 16'h0000;
      thr_hi = 16'hffff;
      persist = 4'h0;
      adc_ch0 = 16'h0000;
      adc_ch1 = 16'h0000;
      tok = 16'h0000;
      t_strap();
      t_conv();
      t_read();
      t_thresh();
      t_alert();
      t_power();
      close_out();
   end

   // the tests need under 3000 cycles
   initial begin
      tick(60000);
      fail_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      close_out();
   end
endmodule

`default_nettype wire
